// ==== phy_special_ctrl_cable_diag_regs.sv ====
/*
 register bank: phy special control/status for both phys, phy 2 cable diagnostic,
 and alias locations in the other bank mapping the same physical bits.
 assumes a single-clock host port: addr, wdata, wr, rd; rdata one cycle after rd.
 phy status and diagnostic inputs arrive asynchronously from the analog phy.
*/
`timescale 1ns/100ps
module phy_special_ctrl_cable_diag_regs
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [phy_regs_pkg::addr_width-1:0] addr,
    input wire logic [phy_regs_pkg::data_width-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [phy_regs_pkg::data_width-1:0] rdata,
    input wire logic [1:0] polarity_reversed,
    input wire logic [1:0] crossover_state,
    input wire logic diag_done,
    input wire logic [1:0] diag_result_in,
    input wire logic diag_short_in,
    input wire logic [8:0] diag_count_in,
    output logic [1:0] force_link,
    output logic [1:0] power_save_off,
    output logic [1:0] loopback,
    output logic diag_start
);
    import phy_regs_pkg::*;

    // two-stage sync for phy status; results are stable when done arrives
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [1:0] pol_s;
    logic [1:0] xover_s;
    logic done_s;
    logic done_d_r;
    logic done_pulse;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            done_d_r <= 1'b0;
        end else begin
            sync1_r <= {diag_done, crossover_state, polarity_reversed};
            sync2_r <= sync1_r;
            done_d_r <= done_s;
        end
    end

    assign pol_s = sync2_r[1:0];
    assign xover_s = sync2_r[3:2];
    assign done_s = sync2_r[4];
    assign done_pulse = done_s & ~done_d_r;

    // address decode, each location and its alias
    wire hit_p1 = (addr == phy1_special_offset);
    wire hit_p1_ctrl = (addr == phy1_alias_ctrl_offset);
    wire hit_p1_stat = (addr == phy1_alias_stat_offset);
    wire hit_diag = (addr == phy2_diag_offset);
    wire hit_p2 = (addr == phy2_special_offset);
    wire hit_p2_ctrl = (addr == phy2_alias_ctrl_offset);
    wire hit_p2_stat = (addr == phy2_alias_stat_offset);

    // gather bits of either layout into force, power, loopback order
    function automatic logic [2:0] ctrl_main(input logic [15:0] d);
        ctrl_main = {d[force_link_bit], d[power_save_off_bit], d[loopback_bit]};
    endfunction

    function automatic logic [2:0] ctrl_alias(input logic [15:0] d);
        ctrl_alias = {d[alias_force_link_bit], d[alias_power_save_off_bit],
                      d[alias_loopback_bit]};
    endfunction

    // same physical bits written from either location
    wire wr_p1 = wr & (hit_p1 | hit_p1_ctrl);
    wire wr_p2 = wr & (hit_p2 | hit_p2_ctrl);
    wire [2:0] bits_p1 = hit_p1 ? ctrl_main(wdata) : ctrl_alias(wdata);
    wire [2:0] bits_p2 = hit_p2 ? ctrl_main(wdata) : ctrl_alias(wdata);

    // start comes through diag offset bit 15 or alias bit 12
    wire start_wr = wr & ((hit_diag & wdata[diag_start_bit]) |
                          (hit_p2_ctrl & wdata[alias_diag_start_bit]));

    phy_ctrl_bits u_ctrl1 (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_p1),
        .wr_bits(bits_p1),
        .force_link(force_link[0]),
        .power_save_off(power_save_off[0]),
        .loopback(loopback[0])
    );

    phy_ctrl_bits u_ctrl2 (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_p2),
        .wr_bits(bits_p2),
        .force_link(force_link[1]),
        .power_save_off(power_save_off[1]),
        .loopback(loopback[1])
    );

    logic [1:0] res;
    logic short_f;
    logic [8:0] cnt;

    cable_diag_ctrl u_diag (
        .mclk(mclk),
        .rst_n(rst_n),
        .start_wr(start_wr),
        .diag_done_in(done_pulse),
        .result_in(diag_result_in),
        .short_in(diag_short_in),
        .count_in(diag_count_in),
        .busy(diag_start),
        .result(res),
        .short_flag(short_f),
        .count(cnt)
    );

    // read images; unlisted bit positions stay zero
    function automatic logic [15:0] special_img(input logic p, input logic x,
                                                input logic f, input logic s,
                                                input logic l);
        logic [15:0] v;
        v = 16'h0000;
        v[polarity_bit] = p;
        v[crossover_state_bit] = x;
        v[force_link_bit] = f;
        v[power_save_off_bit] = s;
        v[loopback_bit] = l;
        special_img = v;
    endfunction

    logic [15:0] img_diag;
    logic [15:0] img_p2_ctrl;
    logic [15:0] img_p1_ctrl;
    logic [15:0] img_p1_stat;
    logic [15:0] img_p2_stat;

    always_comb begin
        img_diag = 16'h0000;
        img_diag[diag_start_bit] = diag_start;
        img_diag[diag_result_hi:diag_result_lo] = res;
        img_diag[short_under_ten_metres_bit] = short_f;
        img_diag[fault_count_hi:0] = cnt;
        // alias control word carries the diag bits, but with start at bit 12 and the short flag at bit 15
        img_p2_ctrl = img_diag;
        img_p2_ctrl[diag_start_bit] = short_f;
        img_p2_ctrl[short_under_ten_metres_bit] = diag_start;
        img_p2_ctrl[alias_force_link_bit] = force_link[1];
        img_p2_ctrl[alias_power_save_off_bit] = power_save_off[1];
        img_p2_ctrl[alias_loopback_bit] = loopback[1];
        img_p1_ctrl = 16'h0000;
        img_p1_ctrl[alias_force_link_bit] = force_link[0];
        img_p1_ctrl[alias_power_save_off_bit] = power_save_off[0];
        img_p1_ctrl[alias_loopback_bit] = loopback[0];
        img_p1_stat = 16'h0000;
        img_p1_stat[alias_polarity_bit] = pol_s[0];
        img_p1_stat[alias_crossover_bit] = xover_s[0];
        img_p2_stat = 16'h0000;
        img_p2_stat[alias_polarity_bit] = pol_s[1];
        img_p2_stat[alias_crossover_bit] = xover_s[1];
    end

    wire [15:0] rd_mux =
        hit_p1 ? special_img(pol_s[0], xover_s[0], force_link[0], power_save_off[0],
                             loopback[0]) :
        hit_p2 ? special_img(pol_s[1], xover_s[1], force_link[1], power_save_off[1],
                             loopback[1]) :
        hit_diag ? img_diag :
        hit_p1_ctrl ? img_p1_ctrl :
        hit_p2_ctrl ? img_p2_ctrl :
        hit_p1_stat ? img_p1_stat :
        hit_p2_stat ? img_p2_stat : 16'h0000;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rd ? rd_mux : 16'h0000;
        end
    end
endmodule

// ==== phy_regs_pkg.sv ====
/*
 package: register offsets, bit positions, reset values for the phy special control,
 status and cable diagnostic registers.
 assumes a 16-bit word register port with one-cycle read latency.
*/
// Overview of operation
// - status bit 5 shows reversed polarity; bit 4 is 1 straight, 0 crossover.
// - control bit 3 forces link pass when 1; resets to 0.
// - control bit 2 is active-low power saving; resets to 1.
// - control bit 1 loops receive pair to transmit pair; resets to 0.
// - writing 1 to diag bit 15 starts test; bit self-clears on completion.
// - results are valid whenever the start bit reads 0.
// - diag bits 14:13 give result code 00/01/10/11; resets to 0.
// - diag bit 12 flags a short closer than ten metres.
// - diag bits 8:0 hold fault count, about 0.4m per count; resets zero.
package phy_regs_pkg;
    localparam int addr_width = 8;
    localparam int data_width = 16;
    localparam logic [7:0] phy1_special_offset = 8'h02;
    localparam logic [7:0] phy2_diag_offset = 8'h04;
    localparam logic [7:0] phy2_special_offset = 8'h06;
    // alias locations in the other bank, same physical bits
    localparam logic [7:0] phy1_alias_ctrl_offset = 8'h10;
    localparam logic [7:0] phy1_alias_stat_offset = 8'h12;
    localparam logic [7:0] phy2_alias_ctrl_offset = 8'h14;
    localparam logic [7:0] phy2_alias_stat_offset = 8'h16;
    localparam int polarity_bit = 5;
    localparam int crossover_state_bit = 4;
    localparam int force_link_bit = 3;
    localparam int power_save_off_bit = 2;
    localparam int loopback_bit = 1;
    localparam int diag_start_bit = 15;
    localparam int diag_result_hi = 14;
    localparam int diag_result_lo = 13;
    localparam int short_under_ten_metres_bit = 12;
    localparam int fault_count_hi = 8;
    localparam int fault_count_width = 9;
    // alias bank bit positions
    localparam int alias_force_link_bit = 11;
    localparam int alias_power_save_off_bit = 10;
    localparam int alias_loopback_bit = 9;
    localparam int alias_diag_start_bit = 12;
    localparam int alias_polarity_bit = 13;
    localparam int alias_crossover_bit = 7;
    localparam int alias_short_bit = 15;
    localparam logic force_link_rst = 1'h0;
    localparam logic power_save_off_rst = 1'h1;
    localparam logic loopback_rst = 1'h0;
    localparam logic [1:0] diag_result_rst = 2'h0;
    localparam logic [8:0] fault_count_rst = 9'h000;
    localparam logic short_rst = 1'h0;
    typedef enum logic [1:0] {
        diag_normal = 2'b00,
        diag_open = 2'b01,
        diag_short = 2'b10,
        diag_failed = 2'b11
    } diag_result_type;
endpackage

// ==== phy_ctrl_bits.sv ====
/*
 per-phy writable control bits: force link, power saving off, loopback.
 assumes write strobes already decoded by the register bank.
*/
`timescale 1ns/100ps
module phy_ctrl_bits
    import phy_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [2:0] wr_bits,
    output logic force_link,
    output logic power_save_off,
    output logic loopback
);
    // wr_bits order: force link, power save off, loopback
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            force_link <= force_link_rst;
            power_save_off <= power_save_off_rst;
            loopback <= loopback_rst;
        end else if (wr_en) begin
            force_link <= wr_bits[2];
            power_save_off <= wr_bits[1];
            loopback <= wr_bits[0];
        end
    end
endmodule

// ==== cable_diag_ctrl.sv ====
/*
 phy 2 cable diagnostic start flag and latched results.
 assumes the analog phy pulses diag_done_in with results on the same cycle,
 and that done is synchronised before it reaches this block.
*/
`timescale 1ns/100ps
module cable_diag_ctrl
    import phy_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start_wr,
    input wire logic diag_done_in,
    input wire logic [1:0] result_in,
    input wire logic short_in,
    input wire logic [8:0] count_in,
    output logic busy,
    output logic [1:0] result,
    output logic short_flag,
    output logic [8:0] count
);
    logic busy_nxt;

    // a start written while done arrives wins: new test begins
    assign busy_nxt = start_wr | (busy & ~diag_done_in);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            result <= diag_result_rst;
            short_flag <= short_rst;
            count <= fault_count_rst;
        end else begin
            busy <= busy_nxt;
            // results only move while busy, so they are stable whenever busy reads 0
            if (busy & diag_done_in) begin
                result <= result_in;
                short_flag <= short_in;
                count <= count_in;
            end
        end
    end
endmodule

// ==== phy_regs_monitor.sv ====
/*
 checker: port-level properties of the phy special control and cable diag bank.
 assumes one clock mclk and a synchronous active-low rst_n.
*/
`timescale 1ns/100ps
module phy_regs_monitor
    import phy_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [phy_regs_pkg::addr_width-1:0] addr,
    input wire logic [phy_regs_pkg::data_width-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [phy_regs_pkg::data_width-1:0] rdata,
    input wire logic diag_done,
    input wire logic [1:0] force_link,
    input wire logic [1:0] power_save_off,
    input wire logic [1:0] loopback,
    input wire logic diag_start
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    rd_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not idle");
    force_wr_a: assert property (wr && addr == phy1_special_offset |=>
        force_link[0] == $past(wdata[force_link_bit])) else $error("force link write lost");
    ctrl_hold_a: assert property (!wr |=>
        $stable({force_link, power_save_off, loopback})) else $error("control moved without write");
    start_set_a: assert property (wr && addr == phy2_diag_offset && wdata[15] |=> diag_start)
        else $error("diag start not set");
    start_clr_a: assert property ($fell(diag_start) |-> $past(diag_done, 2))
        else $error("diag start cleared without done");
    // done needs the synchroniser delay before it may end a test
    start_hold_a: assert property (diag_start && !diag_done && !$past(diag_done) &&
        !$past(diag_done, 2) |=> diag_start) else $error("diag start dropped early");
    rd_ctrl_a: assert property (rd && addr == phy1_special_offset |=> rdata[15:6] == 10'h000 &&
        rdata[3:0] == {force_link[0], power_save_off[0], loopback[0], 1'b0})
        else $error("phy1 control read wrong");
    rd_diag_a: assert property (rd && addr == phy2_diag_offset |=> rdata[11:9] == 3'h0 &&
        rdata[15] == $past(diag_start)) else $error("diag read wrong");
    test_run_c: cover property ($fell(diag_start));
    alias_wr_c: cover property (wr && addr == phy2_alias_ctrl_offset);
    ctrl_rd_c: cover property (rd && addr == phy2_special_offset);
endmodule

// ==== tb_top.sv ====
/*
 testbench: drives the register bank over its host port and checks read data.
 assumes phy_regs_pkg and phy_regs_monitor are compiled first.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    import phy_regs_pkg::*;
    logic mclk = 0, rst_n = 0, wr = 0, rd = 0, done = 0, shrt = 0, ds;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [1:0] pol = 2'h0, xo = 2'h3, res = 2'h0, fl, ps, lb;
    logic [8:0] cnt = 9'h000;
    int error_cnt = 0, total_checks = 0;
    always #4 mclk = ~mclk;
    phy_special_ctrl_cable_diag_regs DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .polarity_reversed(pol),
        .crossover_state(xo), .diag_done(done), .diag_result_in(res), .diag_short_in(shrt),
        .diag_count_in(cnt), .force_link(fl), .power_save_off(ps), .loopback(lb),
        .diag_start(ds));
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        // status pins need two edges through the synchroniser after release
        repeat (2) @(posedge mclk);
        rd_chk(phy1_special_offset, 16'h0014);
        `CHK({fl, ps, lb}, 6'h0C)
        @(posedge mclk);
        pol <= 2'h2;
        xo <= 2'h1;
        repeat (4) @(posedge mclk);
        rd_chk(phy1_special_offset, 16'h0014);
        rd_chk(phy2_special_offset, 16'h0024);
        wr_reg(phy1_special_offset, 16'hFFFF);
        rd_chk(phy1_special_offset, 16'h001E);
        wr_reg(phy2_special_offset, 16'h0000);
        `CHK({fl, ps, lb}, 6'h15)
        rd_chk(phy2_special_offset, 16'h0020);
        wr_reg(phy2_alias_ctrl_offset, 16'h0C00);
        rd_chk(phy2_special_offset, 16'h002C);
        rd_chk(phy1_alias_ctrl_offset, 16'h0E00);
        rd_chk(phy1_alias_stat_offset, 16'h0080);
        wr_reg(8'h08, 16'hFFFF);
        rd_chk(8'h08, 16'h0000);
        // every result code, with count and short flag varied per pass
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            res <= 2'(i);
            shrt <= i[0];
            cnt <= 9'h1A5 - 9'(i);
            // last pass starts through the alias word, control bits rewritten unchanged
            wr_reg(i == 3 ? phy2_alias_ctrl_offset : phy2_diag_offset,
                   i == 3 ? 16'h1C00 : 16'h8000);
            repeat (3) @(posedge mclk);
            `CHK(ds, 1'b1)
            done <= 1'b1;
            for (int k = 0; k < 10 && ds; k++) begin
                @(posedge mclk);
                #1;
            end
            `CHK(ds, 1'b0)
            @(posedge mclk);
            done <= 1'b0;
            rd_chk(phy2_diag_offset, {1'b0, 2'(i), i[0], 3'h0, 9'h1A5 - 9'(i)});
            wr_reg(phy2_diag_offset, 16'h7FFF);
            rd_chk(phy2_diag_offset, {1'b0, 2'(i), i[0], 3'h0, 9'h1A5 - 9'(i)});
        end
        rd_chk(phy2_alias_ctrl_offset, 16'hEDA2);
        rd_chk(phy2_alias_stat_offset, 16'h2000);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        `CHK({fl, ps, lb, ds}, 7'h18)
        rd_chk(phy2_diag_offset, 16'h0000);
        stop_test();
    end
    // whole run is under two hundred cycles; this limit only catches a hang
    initial begin
        #(5000 * 8);
        error_cnt++;
        stop_test();
    end
endmodule
bind phy_special_ctrl_cable_diag_regs phy_regs_monitor mon (.mclk, .rst_n, .addr, .wdata,
    .wr, .rd, .rdata, .diag_done, .force_link, .power_save_off, .loopback, .diag_start);
